// file: wpm_partner.sv
// Model of the wake-up pins and oscillator beside the block
`timescale 1ns/1ps
module wpm_partner (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Requests from the bench
   input wire logic [15:0] line_req_i,
   input wire logic osc_en_i,
   // Pins seen by the block
   output logic [15:0] lines_o,
   output logic osc_run_o
);
   logic [1:0] osc_q; // Start-up delay of the oscillator
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         lines_o <= 16'hFFFF;
         osc_q <= 2'h0;
      end else begin
         lines_o <= line_req_i;
         // Oscillation begins three cycles after enable
         osc_q <= osc_en_i ? osc_q + {1'b0, ~&osc_q} : 2'h0;
      end
   end
   assign osc_run_o = &osc_q;
endmodule : wpm_partner

// file: wpm_pkg.sv
// Constants and types of the wake-up, priority and power-mode block
package wpm_pkg;
   // Register indices as printed, byte address is four times the index
   localparam logic [11:0] WPM_IDX_POL_HIGH = 12'h0FC;
   localparam logic [11:0] WPM_IDX_POL_LOW = 12'h0FD;
   localparam logic [11:0] WPM_IDX_PRIO_LOW = 12'h0FD;
   // Page windows that separate equal indices
   localparam logic [11:0] WPM_PAGE_WAKE = 12'h000;
   localparam logic [11:0] WPM_PAGE_PRIO = 12'h400;
   // Byte addresses on the bus
   localparam logic [11:0] WPM_ADR_POL_HIGH = WPM_PAGE_WAKE + (WPM_IDX_POL_HIGH << 2);
   localparam logic [11:0] WPM_ADR_POL_LOW = WPM_PAGE_WAKE + (WPM_IDX_POL_LOW << 2);
   localparam logic [11:0] WPM_ADR_PRIO_LOW = WPM_PAGE_PRIO + (WPM_IDX_PRIO_LOW << 2);
   localparam logic [11:0] WPM_ADR_MASK = 12'h000;
   localparam logic [11:0] WPM_ADR_PEND = 12'h004;
   localparam logic [11:0] WPM_ADR_CTRL = 12'h008;
   localparam logic [11:0] WPM_ADR_STAT = 12'h00C;
   localparam logic [11:0] WPM_ADR_EXT_CFG = 12'h010;
   localparam logic [11:0] WPM_ADR_EXT_PEND = 12'h014;
   // Reset values
   localparam logic [7:0] WPM_RST_POL = 8'h00;
   localparam logic [7:0] WPM_RST_PRIO = 8'hFF;
   localparam logic [15:0] WPM_RST_MASK = 16'h0000;
   // Control register fields
   localparam int WPM_CTRL_ROUTE = 0;
   localparam int WPM_CTRL_EVENT = 1;
   localparam int WPM_CTRL_STOP = 2;
   localparam int WPM_CTRL_PLL = 3;
   // Status register fields
   localparam int WPM_STAT_RUN = 0;
   localparam int WPM_STAT_WAIT = 1;
   localparam int WPM_STAT_STOP = 2;
   localparam int WPM_STAT_STAB = 3;
   localparam int WPM_STAT_HALT = 4;
   localparam int WPM_STAT_PLL = 5;
   localparam int WPM_STAT_WIRQ = 6;
   localparam int WPM_STAT_WEVT = 7;
   // Oscillator settling time and clock rate
   localparam int WPM_STAB_TIME_US = 5000;
   localparam int WPM_CLK_MHZ = 100;
   localparam int WPM_STAB_CYCLES = WPM_STAB_TIME_US * WPM_CLK_MHZ;
   // Power modes
   typedef enum logic [2:0] {
      WPM_RUN,
      WPM_WAIT,
      WPM_STOP,
      WPM_STAB,
      WPM_HALT
   } wpm_mode_t;
endpackage : wpm_pkg

// file: wpm_props.sv
// Checker on the ports of the wake-up, priority and power-mode block
`timescale 1ns/1ps
module wpm_props #(
   parameter int NUM_EXT = 8,
   parameter int STAB_CYCLES = 8
) (
   // Clock, reset and bus select
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic PSEL_I,
   // Core requests and pins
   input wire logic WFI_REQ_I,
   input wire logic HALT_REQ_I,
   input wire logic WDOG_EN_I,
   input wire logic IRQ_ACK_I,
   input wire logic NMI_I,
   input wire logic OSC_RUNNING_I,
   // Mode and interrupt outputs
   input wire logic CPU_CLK_EN_O,
   input wire logic PERIPH_CLK_EN_O,
   input wire logic OSC_EN_O,
   input wire logic PLL_SEL_O,
   input wire logic WDOG_RUN_O,
   input wire logic WAKE_IRQ_O,
   input wire logic WAKE_EVENT_O,
   input wire logic IRQ_REQ_O,
   input wire logic SAVE_CTX_O,
   input wire logic [3*NUM_EXT-1:0] CHAN_PRIO_O
);
   logic stab; // Settling after a stop
   int cnt_q; // Oscillator cycles seen while settling
   int cnt_d; // Next count
   assign stab = OSC_EN_O && !PERIPH_CLK_EN_O;
   // Count only while the oscillator runs
   always_comb begin
      cnt_d = stab ? cnt_q + int'(OSC_RUNNING_I) : 0;
   end
   // Register the count
   always_ff @(posedge REF_CLK_I) begin
      cnt_q <= RST_N_I ? cnt_d : 0;
   end
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // Running with no register transfer near
   sequence quiet_s;
      CPU_CLK_EN_O && !PSEL_I && !$past(PSEL_I);
   endsequence
   // Peripheral clock, oscillator and watchdog frozen
   sequence frozen_s;
      !PERIPH_CLK_EN_O && !OSC_EN_O && !WDOG_RUN_O;
   endsequence
   wait_entry_a: assert property (quiet_s ##0 (WFI_REQ_I && !HALT_REQ_I)
      |=> !CPU_CLK_EN_O && PERIPH_CLK_EN_O) else $error("wait not entered");
   wait_exit_a: assert property (!CPU_CLK_EN_O && PERIPH_CLK_EN_O && IRQ_ACK_I
      |=> CPU_CLK_EN_O) else $error("wait not left");
   halt_freeze_a: assert property (quiet_s ##0 (HALT_REQ_I && !WDOG_EN_I)
      |=> frozen_s [*8]) else $error("halt not held");
   stop_hold_a: assert property (!OSC_EN_O && !WAKE_EVENT_O && !NMI_I
      |=> frozen_s) else $error("stop left without wake");
   stab_hold_a: assert property ($rose(OSC_EN_O)
      |-> !CPU_CLK_EN_O && !WDOG_RUN_O && !PLL_SEL_O) else $error("settling wrong");
   stab_len_a: assert property ($rose(CPU_CLK_EN_O) && $past(stab)
      |-> cnt_q >= STAB_CYCLES && cnt_q <= STAB_CYCLES + 1) else $error("settling length");
   event_irq_a: assert property (WAKE_EVENT_O |-> WAKE_IRQ_O) else $error("lone event");
   prio_reset_a: assert property ($rose(RST_N_I)
      |-> CHAN_PRIO_O == {NUM_EXT/2{3'h7, 3'h6}}) else $error("priority reset wrong");
   save_ctx_a: assert property (IRQ_ACK_I && IRQ_REQ_O && PERIPH_CLK_EN_O
      |=> SAVE_CTX_O) else $error("context not saved");
endmodule : wpm_props

// file: wpm_top.sv
// Power-mode sequencer, pair priority encoder and wake-up line unit
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps

// Summary of operation
// - Stop sequence with NMI low stops CPU, peripherals.
// - Only wake-up line or NMI ends STOP.
// - Registers kept through STOP except the PLL bit, which is cleared; no reset made.
// - Watchdog frozen in STOP, resumes afterwards.
// - Settling counter after oscillator restarts holds operation.
// - Oscillator off in STOP, PLL deselected.
// - Halt without watchdog freezes all until reset.
// - Wait gates CPU clock until interrupt acknowledged.
// - Winning enabled request saves status, vectors.
// - Eight external interrupts with selectable edge.
// - Priority register holds two bits per pair.
// - Three-bit priority, zero highest, seven lowest.
// - Even channel low bit zero, odd one.
// - Priority register resets to all ones.
// - Route and event enabled: interrupt plus event.
// - Route only: interrupt, no wake-up event.
// - Cleared mask bit never gives wake-up event.
// - Polarity zero falling edge, one rising edge.
// - Two eight-bit polarity registers, reset zero.
// - Wake-up edge during polarity write sets nothing; external edges still set pending.
module wpm_top #(
   parameter int NUM_WAKE = 16,
   parameter int NUM_EXT = 8,
   parameter int STAB_CYCLES = wpm_pkg::WPM_STAB_CYCLES
) (
   // Clock and reset
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   // APB slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // CPU core requests
   input wire logic WFI_REQ_I,
   input wire logic HALT_REQ_I,
   input wire logic WDOG_EN_I,
   input wire logic IRQ_ACK_I,
   // External pins and oscillator
   input wire logic NMI_I,
   input wire logic [NUM_WAKE-1:0] WAKE_LINES_I,
   input wire logic [NUM_EXT-1:0] EXT_INT_I,
   input wire logic OSC_RUNNING_I,
   // Clock and mode controls
   output logic CPU_CLK_EN_O,
   output logic PERIPH_CLK_EN_O,
   output logic OSC_EN_O,
   output logic PLL_SEL_O,
   output logic WDOG_RUN_O,
   // Interrupt outputs
   output logic WAKE_IRQ_O,
   output logic WAKE_EVENT_O,
   output logic IRQ_REQ_O,
   output logic [2:0] IRQ_CHAN_O,
   output logic [2:0] IRQ_LEVEL_O,
   output logic SAVE_CTX_O,
   output logic [3*NUM_EXT-1:0] CHAN_PRIO_O
);
   import wpm_pkg::*;

   // Refuse sizes the register map cannot serve
   if (NUM_WAKE != 16 || NUM_EXT != 8 || STAB_CYCLES < 1 || STAB_CYCLES > 1048575) begin : g_chk
      $error("wpm_top: unsupported parameter values");
   end

   // Register state and next values
   logic [7:0] pol_high_q, pol_high_d;     // Polarity of lines 15..8
   logic [7:0] pol_low_q, pol_low_d;       // Polarity of lines 7..0
   logic [7:0] prio_q, prio_d;             // Pair priority fields
   logic [15:0] mask_q, mask_d;            // Wake-up line masks
   logic route_q, route_d;                 // Wake-up interrupt routing
   logic evt_en_q, evt_en_d;               // Wake-up event enable
   logic pll_q, pll_d;                     // PLL as CPU clock source
   logic [1:0] seq_q, seq_d;               // Stop write sequence step
   logic stop_req;                         // Completed stop sequence
   logic [NUM_EXT-1:0] ext_en_q, ext_en_d; // External interrupt enables
   logic [NUM_EXT-1:0] ext_rise_q, ext_rise_d; // External edge select
   // Pending and edge state
   logic [15:0] pend_q, pend_d;            // Wake-up pending bits
   logic [15:0] wake_prev_q;               // Previous wake-up levels
   logic [NUM_EXT-1:0] ext_pend_q, ext_pend_d; // External pending bits
   logic [NUM_EXT-1:0] ext_prev_q;         // Previous external levels
   // Mode state
   wpm_mode_t mode_q, mode_d;              // Power mode
   logic [19:0] stab_q, stab_d;            // Settling countdown
   logic save_q, save_d;                   // Context save strobe
   // Bus and decode
   logic wr_en;                            // Write takes effect
   logic rd_setup;                         // Read data captured
   logic [31:0] rdata_q, rdata_d;          // Registered read data
   logic err_q, err_d;                     // Unmapped address flag
   logic hit;                              // Address is mapped
   logic [15:0] polarity;                  // All polarity bits
   logic [15:0] wake_edge;                 // Qualified wake-up edges
   logic [NUM_EXT-1:0] ext_edge;           // Qualified external edges
   logic [15:0] wake_active;               // Mask and pending both set
   logic [NUM_EXT-1:0] ext_live;           // Pending and enabled
   logic [2:0] chan_prio [NUM_EXT];        // Per channel priority
   logic [2:0] win_chan;                   // Arbitration winner
   logic [2:0] win_lvl;                    // Winner priority
   logic win_any;                          // Some request live
   logic pol_write;                        // Polarity register written
   logic [7:0] stat;                       // Status read value

   // Bus phase decode, no wait states
   assign wr_en = PSEL_I && PENABLE_I && PWRITE_I;
   assign rd_setup = PSEL_I && !PENABLE_I;
   assign PREADY_O = PSEL_I && PENABLE_I;
   assign PRDATA_O = rdata_q;
   assign PSLVERR_O = PREADY_O && err_q;

   // Address hit for the mapped set
   always_comb begin
      unique case (PADDR_I)
         WPM_ADR_POL_HIGH, WPM_ADR_POL_LOW, WPM_ADR_PRIO_LOW, WPM_ADR_MASK,
         WPM_ADR_PEND, WPM_ADR_CTRL, WPM_ADR_STAT, WPM_ADR_EXT_CFG,
         WPM_ADR_EXT_PEND: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   // Per channel priority: pair bits above, fixed parity bit below
   for (genvar i = 0; i < NUM_EXT; i++) begin : g_prio
      assign chan_prio[i] = {prio_q[2*(i/2)+1], prio_q[2*(i/2)], 1'(i % 2)};
      assign CHAN_PRIO_O[3*i +: 3] = chan_prio[i];
   end

   // Edge qualification for wake-up and external lines
   assign polarity = {pol_high_q, pol_low_q};
   assign pol_write = wr_en && (PADDR_I == WPM_ADR_POL_HIGH || PADDR_I == WPM_ADR_POL_LOW);
   always_comb begin
      for (int i = 0; i < 16; i++) begin
         wake_edge[i] = polarity[i] ? (WAKE_LINES_I[i] && !wake_prev_q[i])
                                    : (!WAKE_LINES_I[i] && wake_prev_q[i]);
      end
      if (pol_write) begin
         wake_edge = 16'h0000;
      end
      for (int i = 0; i < NUM_EXT; i++) begin
         ext_edge[i] = ext_rise_q[i] ? (EXT_INT_I[i] && !ext_prev_q[i])
                                     : (!EXT_INT_I[i] && ext_prev_q[i]);
      end
   end

   // Wake-up interrupt and event generation
   assign wake_active = mask_q & pend_q;
   assign WAKE_IRQ_O = (|wake_active) && route_q;
   assign WAKE_EVENT_O = (|wake_active) && route_q && evt_en_q;

   // Arbitration among live external channels, lowest level wins
   assign ext_live = ext_pend_q & ext_en_q;
   always_comb begin
      win_any = 1'b0;
      win_chan = 3'h0;
      win_lvl = 3'h7;
      for (int i = 0; i < NUM_EXT; i++) begin
         if (ext_live[i] && (!win_any || chan_prio[i] < win_lvl)) begin
            win_any = 1'b1;
            win_chan = 3'(i);
            win_lvl = chan_prio[i];
         end
      end
   end
   assign IRQ_REQ_O = win_any;
   assign IRQ_CHAN_O = win_chan;
   assign IRQ_LEVEL_O = win_lvl;
   assign SAVE_CTX_O = save_q;

   // Next values of the software registers and stop sequence
   always_comb begin
      pol_high_d = pol_high_q;
      pol_low_d = pol_low_q;
      prio_d = prio_q;
      mask_d = mask_q;
      route_d = route_q;
      evt_en_d = evt_en_q;
      pll_d = pll_q;
      seq_d = seq_q;
      ext_en_d = ext_en_q;
      ext_rise_d = ext_rise_q;
      stop_req = 1'b0;
      if (wr_en) begin
         unique case (PADDR_I)
            WPM_ADR_POL_HIGH: pol_high_d = PWDATA_I[7:0];
            WPM_ADR_POL_LOW: pol_low_d = PWDATA_I[7:0];
            WPM_ADR_PRIO_LOW: prio_d = PWDATA_I[7:0];
            WPM_ADR_MASK: mask_d = PWDATA_I[15:0];
            WPM_ADR_EXT_CFG: begin
               ext_en_d = PWDATA_I[NUM_EXT-1:0];
               ext_rise_d = PWDATA_I[2*NUM_EXT-1:NUM_EXT];
            end
            WPM_ADR_CTRL: begin
               route_d = PWDATA_I[WPM_CTRL_ROUTE];
               evt_en_d = PWDATA_I[WPM_CTRL_EVENT];
               pll_d = PWDATA_I[WPM_CTRL_PLL];
               // Stop bit written one, zero, one in a row
               unique case (seq_q)
                  2'h0: seq_d = PWDATA_I[WPM_CTRL_STOP] ? 2'h1 : 2'h0;
                  2'h1: seq_d = PWDATA_I[WPM_CTRL_STOP] ? 2'h1 : 2'h2;
                  2'h2: begin
                     seq_d = 2'h0;
                     stop_req = PWDATA_I[WPM_CTRL_STOP];
                  end
                  default: seq_d = 2'h0;
               endcase
            end
            default: begin
            end
         endcase
      end
      if (mode_q == WPM_STOP) begin
         pll_d = 1'b0;
      end
   end

   // Software registers
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         pol_high_q <= WPM_RST_POL;
         pol_low_q <= WPM_RST_POL;
         prio_q <= WPM_RST_PRIO;
         mask_q <= WPM_RST_MASK;
         route_q <= 1'b0;
         evt_en_q <= 1'b0;
         pll_q <= 1'b0;
         seq_q <= 2'h0;
         ext_en_q <= '0;
         ext_rise_q <= '0;
      end else begin
         pol_high_q <= pol_high_d;
         pol_low_q <= pol_low_d;
         prio_q <= prio_d;
         mask_q <= mask_d;
         route_q <= route_d;
         evt_en_q <= evt_en_d;
         pll_q <= pll_d;
         seq_q <= seq_d;
         ext_en_q <= ext_en_d;
         ext_rise_q <= ext_rise_d;
      end
   end

   // Pending bits: set wins over software or acknowledge clear
   always_comb begin
      pend_d = pend_q;
      ext_pend_d = ext_pend_q;
      if (wr_en && PADDR_I == WPM_ADR_PEND) begin
         pend_d = pend_d & ~PWDATA_I[15:0];
      end
      if (wr_en && PADDR_I == WPM_ADR_EXT_PEND) begin
         ext_pend_d = ext_pend_d & ~PWDATA_I[NUM_EXT-1:0];
      end
      if (IRQ_ACK_I && win_any) begin
         ext_pend_d[win_chan] = 1'b0;
      end
      pend_d = pend_d | wake_edge;
      ext_pend_d = ext_pend_d | ext_edge;
   end

   // Pending and edge history registers
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         pend_q <= 16'h0000;
         ext_pend_q <= '0;
         wake_prev_q <= 16'h0000;
         ext_prev_q <= '0;
      end else begin
         pend_q <= pend_d;
         ext_pend_q <= ext_pend_d;
         wake_prev_q <= WAKE_LINES_I;
         ext_prev_q <= EXT_INT_I;
      end
   end

   // Power mode sequencing
   always_comb begin
      mode_d = mode_q;
      stab_d = stab_q;
      save_d = 1'b0;
      unique case (mode_q)
         WPM_RUN: begin
            if (stop_req && !NMI_I) begin
               mode_d = WPM_STOP;
            end else if (HALT_REQ_I && !WDOG_EN_I) begin
               mode_d = WPM_HALT;
            end else if (WFI_REQ_I) begin
               mode_d = WPM_WAIT;
            end
         end
         WPM_WAIT: begin
            if (IRQ_ACK_I) begin
               mode_d = WPM_RUN;
            end
         end
         WPM_STOP: begin
            if (WAKE_EVENT_O || NMI_I) begin
               mode_d = WPM_STAB;
               stab_d = 20'(STAB_CYCLES);
            end
         end
         WPM_STAB: begin
            if (OSC_RUNNING_I) begin
               if (stab_q <= 20'h00001) begin
                  mode_d = WPM_RUN;
                  stab_d = 20'h00000;
               end else begin
                  stab_d = stab_q - 20'h00001;
               end
            end
         end
         WPM_HALT: begin
            mode_d = WPM_HALT;
         end
         default: mode_d = WPM_RUN;
      endcase
      if (IRQ_ACK_I && win_any && mode_q != WPM_STOP && mode_q != WPM_HALT) begin
         save_d = 1'b1;
      end
   end

   // Mode registers; no reset is ever raised on stop exit
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         mode_q <= WPM_RUN;
         stab_q <= 20'h00000;
         save_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         stab_q <= stab_d;
         save_q <= save_d;
      end
   end

   // Clock gating outputs per mode
   // only CPU clock off in wait
   assign CPU_CLK_EN_O = (mode_q == WPM_RUN);
   assign PERIPH_CLK_EN_O = (mode_q == WPM_RUN) || (mode_q == WPM_WAIT);
   assign OSC_EN_O = (mode_q != WPM_STOP) && (mode_q != WPM_HALT);
   assign PLL_SEL_O = pll_q;
   assign WDOG_RUN_O = (mode_q == WPM_RUN) || (mode_q == WPM_WAIT);

   // Status word
   always_comb begin
      stat = 8'h00;
      stat[WPM_STAT_RUN] = (mode_q == WPM_RUN);
      stat[WPM_STAT_WAIT] = (mode_q == WPM_WAIT);
      stat[WPM_STAT_STOP] = (mode_q == WPM_STOP);
      stat[WPM_STAT_STAB] = (mode_q == WPM_STAB);
      stat[WPM_STAT_HALT] = (mode_q == WPM_HALT);
      stat[WPM_STAT_PLL] = pll_q;
      stat[WPM_STAT_WIRQ] = WAKE_IRQ_O;
      stat[WPM_STAT_WEVT] = WAKE_EVENT_O;
   end

   // Read data captured in the setup cycle
   always_comb begin
      rdata_d = rdata_q;
      err_d = err_q;
      if (rd_setup) begin
         err_d = !hit;
         rdata_d = 32'h00000000;
         unique case (PADDR_I)
            WPM_ADR_POL_HIGH: rdata_d[7:0] = pol_high_q;
            WPM_ADR_POL_LOW: rdata_d[7:0] = pol_low_q;
            WPM_ADR_PRIO_LOW: rdata_d[7:0] = prio_q;
            WPM_ADR_MASK: rdata_d[15:0] = mask_q;
            WPM_ADR_PEND: rdata_d[15:0] = pend_q;
            WPM_ADR_CTRL: begin
               rdata_d[WPM_CTRL_ROUTE] = route_q;
               rdata_d[WPM_CTRL_EVENT] = evt_en_q;
               rdata_d[WPM_CTRL_PLL] = pll_q;
            end
            WPM_ADR_STAT: rdata_d[7:0] = stat;
            WPM_ADR_EXT_CFG: rdata_d[2*NUM_EXT-1:0] = {ext_rise_q, ext_en_q};
            WPM_ADR_EXT_PEND: rdata_d[NUM_EXT-1:0] = ext_pend_q;
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // Read data registers
   always_ff @(posedge REF_CLK_I) begin
      if (!RST_N_I) begin
         rdata_q <= 32'h00000000;
         err_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         err_q <= err_d;
      end
   end
endmodule : wpm_top

// file: wpm_top_tb_top.sv
// Self-checking bench of the wake-up, priority and power-mode block
`timescale 1ns/1ps
module wpm_top_tb_top;
   import wpm_pkg::*;
   // Register row: address, reset, write, readback, error
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] r;
      logic [31:0] w;
      logic [31:0] x;
      logic e;
   } wpm_row_t;
   localparam int STAB = 8; // Shortened settling count
   logic clk, rst_n, psel, pen, pwr, rdy, err, re; // Clock, reset, bus controls
   logic [11:0] paddr; // Bus address
   logic [31:0] pwdata, prdata, rd; // Bus data and last read
   logic wait_for_interrupt_mode, halt, wdog, ack, nmi, osc_run; // Core requests and pins
   logic cpu, per, osc, pll, wdr, wirq, wevt, ireq, save; // Block outputs
   logic [15:0] line_req, lines; // Wake-up lines asked for and seen
   logic [7:0] ext; // External interrupt inputs
   logic [2:0] ichan, ilev; // Winning channel and level
   logic [23:0] cprio, eprio; // Channel priorities seen and expected
   int errors, comparisons, n; // Counters
   wpm_row_t rows [7] = '{
      '{WPM_ADR_POL_HIGH, 32'h0, 32'hA5, 32'hA5, 1'b0},
      '{WPM_ADR_POL_LOW, 32'h0, 32'h3C, 32'h3C, 1'b0},
      '{WPM_ADR_PRIO_LOW, 32'hFF, 32'h1B, 32'h1B, 1'b0},
      '{WPM_ADR_MASK, 32'h0, 32'hFFFFFFFF, 32'hFFFF, 1'b0},
      '{WPM_ADR_EXT_CFG, 32'h0, 32'hFFFF, 32'hFFFF, 1'b0},
      '{WPM_ADR_CTRL, 32'h0, 32'hF, 32'hB, 1'b0},
      '{12'h100, 32'h0, 32'h5A, 32'h0, 1'b1}};
   wpm_top #(.STAB_CYCLES(STAB)) u_wpm_top (
      .REF_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
      .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(rdy), .PSLVERR_O(err),
      .WFI_REQ_I(wait_for_interrupt_mode), .HALT_REQ_I(halt), .WDOG_EN_I(wdog), .IRQ_ACK_I(ack), .NMI_I(nmi),
      .WAKE_LINES_I(lines), .EXT_INT_I(ext), .OSC_RUNNING_I(osc_run), .CPU_CLK_EN_O(cpu),
      .PERIPH_CLK_EN_O(per), .OSC_EN_O(osc), .PLL_SEL_O(pll), .WDOG_RUN_O(wdr),
      .WAKE_IRQ_O(wirq), .WAKE_EVENT_O(wevt), .IRQ_REQ_O(ireq), .IRQ_CHAN_O(ichan),
      .IRQ_LEVEL_O(ilev), .SAVE_CTX_O(save), .CHAN_PRIO_O(cprio));
   wpm_partner u_wpm_partner (.clk_i(clk), .rst_n_i(rst_n), .line_req_i(line_req),
      .osc_en_i(osc), .lines_o(lines), .osc_run_o(osc_run));
   // Free-running clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // One APB transfer and an idle cycle, entered just after an edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (rdy !== 1'b1) @(posedge clk);
      rd = prdata;
      re = err;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask : apb
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("FAIL at %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic chk1(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask : chk1
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask : tick
   // Verdict and end of run
   task automatic end_of_test();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test
   // Cut a hang short
   initial begin
      #100000;
      errors++;
      end_of_test();
   end
   // Main sequence
   initial begin
      {rst_n, psel, pen, pwr, wait_for_interrupt_mode, halt, wdog, ack, nmi, ext, paddr, pwdata} = '0;
      line_req = 16'hFFFF;
      errors = 0;
      comparisons = 0;
      tick(8);
      rst_n <= 1'b1;
      tick(1);
      // Register reset, write and readback
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].r);
         apb(1'b1, rows[i].a, rows[i].w);
         chk1(re, rows[i].e);
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].x);
      end
      for (int i = 0; i < 8; i++) eprio[3*i+:3] = {rows[2].x[2*(i/2)+:2], i[0]};
      chk(32'(cprio), 32'(eprio));
      // External requests, wait mode and acknowledge
      ext <= 8'hFF;
      tick(3);
      chk(32'({ireq, ichan, ilev}), 32'h70);
      wait_for_interrupt_mode <= 1'b1;
      tick(1);
      wait_for_interrupt_mode <= 1'b0;
      tick(2);
      chk(32'({cpu, per}), 32'h1);
      ack <= 1'b1;
      tick(1);
      ack <= 1'b0;
      tick(1);
      chk(32'({save, cpu, ichan, ilev}), 32'hF9);
      // Acknowledged channel cleared, then falling edge selection
      apb(1'b0, WPM_ADR_EXT_PEND, 32'h0);
      chk(rd, 32'hBF);
      apb(1'b1, WPM_ADR_EXT_CFG, 32'hFF);
      apb(1'b1, WPM_ADR_EXT_PEND, 32'hFF);
      ext <= 8'hFE;
      tick(3);
      chk(32'({ireq, ichan, ilev}), 32'h46);
      // Wake-up edges and outputs
      line_req <= 16'hFFFE;
      tick(3);
      chk(32'({wirq, wevt}), 32'h3);
      apb(1'b0, WPM_ADR_PEND, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, WPM_ADR_PEND, 32'h1);
      line_req <= 16'hFFFB;
      tick(3);
      apb(1'b0, WPM_ADR_PEND, 32'h0);
      chk(rd, 32'h0);
      line_req <= 16'hFFFF;
      tick(3);
      apb(1'b0, WPM_ADR_PEND, 32'h0);
      chk(rd, 32'h4);
      apb(1'b1, WPM_ADR_CTRL, 32'h9);
      chk(32'({wirq, wevt}), 32'h2);
      apb(1'b1, WPM_ADR_MASK, 32'h0);
      // Event enabled again so only the mask can hold it off
      apb(1'b1, WPM_ADR_CTRL, 32'hB);
      line_req <= 16'hFFFE;
      tick(3);
      chk(32'({wirq, wevt}), 32'h0);
      apb(1'b0, WPM_ADR_PEND, 32'h0);
      chk(rd, 32'h5);
      apb(1'b1, WPM_ADR_PEND, 32'hFFFF);
      line_req <= 16'hFFFC;
      apb(1'b1, WPM_ADR_POL_HIGH, 32'hA5);
      tick(2);
      apb(1'b0, WPM_ADR_PEND, 32'h0);
      chk(rd, 32'h0);
      // Stop refused, then left by a line and by NMI
      apb(1'b1, WPM_ADR_MASK, 32'hFFFF);
      line_req <= 16'hFFFF;
      for (int k = 0; k < 3; k++) begin
         nmi <= (k == 0);
         apb(1'b1, WPM_ADR_PEND, 32'hFFFF);
         apb(1'b1, WPM_ADR_CTRL, 32'hF);
         apb(1'b1, WPM_ADR_CTRL, 32'hB);
         apb(1'b1, WPM_ADR_CTRL, 32'hF);
         tick(3);
         nmi <= 1'b0;
         chk(32'({cpu, per, osc, wdr}), (k == 0) ? 32'hF : 32'h0);
         if (k > 0) begin
            tick(5);
            chk1(osc, 1'b0);
            apb(1'b0, WPM_ADR_STAT, 32'h0);
            chk(rd, 32'h4);
            if (k == 1)
               line_req <= 16'hFFFE;
            else
               nmi <= 1'b1;
            n = 0;
            while (cpu !== 1'b1 && n < 100) begin
               tick(1);
               n++;
            end
            nmi <= 1'b0;
            chk1(n > STAB, 1'b1);
            chk1(pll, 1'b0);
            apb(1'b0, WPM_ADR_POL_HIGH, 32'h0);
            chk(rd, 32'hA5);
         end
      end
      // Halt ignored with watchdog on, then held until reset
      wdog <= 1'b1;
      halt <= 1'b1;
      tick(1);
      halt <= 1'b0;
      tick(3);
      chk1(cpu, 1'b1);
      wdog <= 1'b0;
      halt <= 1'b1;
      tick(1);
      halt <= 1'b0;
      nmi <= 1'b1;
      tick(9);
      chk(32'({cpu, per, osc}), 32'h0);
      nmi <= 1'b0;
      rst_n <= 1'b0;
      tick(2);
      rst_n <= 1'b1;
      tick(2);
      chk1(cpu, 1'b1);
      apb(1'b0, WPM_ADR_PRIO_LOW, 32'h0);
      chk(rd, 32'hFF);
      end_of_test();
   end
endmodule : wpm_top_tb_top
bind wpm_top wpm_props #(.NUM_EXT(NUM_EXT), .STAB_CYCLES(STAB_CYCLES)) u_wpm_props (
   .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .WFI_REQ_I(WFI_REQ_I),
   .HALT_REQ_I(HALT_REQ_I), .WDOG_EN_I(WDOG_EN_I), .IRQ_ACK_I(IRQ_ACK_I), .NMI_I(NMI_I),
   .OSC_RUNNING_I(OSC_RUNNING_I), .CPU_CLK_EN_O(CPU_CLK_EN_O), .OSC_EN_O(OSC_EN_O),
   .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O), .PLL_SEL_O(PLL_SEL_O), .WDOG_RUN_O(WDOG_RUN_O),
   .WAKE_IRQ_O(WAKE_IRQ_O), .WAKE_EVENT_O(WAKE_EVENT_O), .IRQ_REQ_O(IRQ_REQ_O),
   .SAVE_CTX_O(SAVE_CTX_O), .CHAN_PRIO_O(CHAN_PRIO_O));
